// >>> hdl/alg_pkg.sv
// Constants and carrier types for the audio link global status register
package alg_pkg;

  // ********************************************************************
  // Register placement and reset value
  // ********************************************************************
  localparam logic [15:0] ALG_LGS_OFFSET = 16'h0030;   // From the bus-master I/O base
  localparam logic [31:0] ALG_LGS_RESET  = 32'h0070_0000;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int ALG_POS_L2_RESUME  = 29;
  localparam int ALG_POS_L2_READY   = 28;
  localparam int ALG_POS_BCLK_STOP  = 27;
  localparam int ALG_POS_SPDIF_IRQ  = 26;
  localparam int ALG_POS_PCM2_IRQ   = 25;
  localparam int ALG_POS_MIC2_IRQ   = 24;
  localparam int ALG_POS_SAMPLE_LSB = 22;
  localparam int ALG_POS_MULTI_LSB  = 20;
  localparam int ALG_POS_MODEM_SEM  = 17;
  localparam int ALG_POS_AUDIO_SEM  = 16;
  localparam int ALG_POS_READ_TMO   = 15;
  localparam int ALG_POS_GPI_LSB    = 12;
  localparam int ALG_POS_L1_RESUME  = 11;
  localparam int ALG_POS_L0_RESUME  = 10;
  localparam int ALG_POS_L1_READY   = 9;
  localparam int ALG_POS_L0_READY   = 8;
  localparam int ALG_POS_GPI_CHG    = 0;

  // Capability fields are fixed by the reset value
  localparam logic [1:0] ALG_SAMPLE_CAP = ALG_LGS_RESET[23:22];
  localparam logic [1:0] ALG_MULTI_CAP  = ALG_LGS_RESET[21:20];

  // ********************************************************************
  // Bit clock watchdog timing
  // ********************************************************************
  localparam int ALG_BCLK_STOP_PCI_CLOCKS = 4;        // Stop window in PCI clocks
  localparam int ALG_PCI_PERIOD_PS        = 30000;
  localparam int ALG_CLK_PERIOD_PS        = 5000;
  localparam int ALG_BCLK_STOP_PS         = ALG_BCLK_STOP_PCI_CLOCKS * ALG_PCI_PERIOD_PS;
  localparam int ALG_BCLK_STOP_CYCLES     =
    (ALG_BCLK_STOP_PS + ALG_CLK_PERIOD_PS - 1) / ALG_CLK_PERIOD_PS;
  localparam logic [4:0] ALG_BCLK_STOP_LIMIT = 5'(ALG_BCLK_STOP_CYCLES);

  // ********************************************************************
  // Widths and carriers
  // ********************************************************************
  localparam int ALG_CH_STAT_W = 3;                   // Status bits per DMA channel
  localparam int ALG_LINES     = 3;                   // Serial data input lines

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } alg_io_req_t;

  typedef struct packed {
    logic [ALG_CH_STAT_W-1:0] spdif;
    logic [ALG_CH_STAT_W-1:0] pcm_in2;
    logic [ALG_CH_STAT_W-1:0] mic_in2;
  } alg_chan_stat_t;

endpackage

// >>> hdl/alg_status.sv
// Global status register of the audio link controller
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Line-2 resume event sets its flag; a software write of 1 or a core reset clears it.
// - Lines 1 and 0 resume events set own flags; write 1 clears each.
// - Function reset leaves resume, timeout and semaphore bits untouched.
// - Three read-only codec-ready bits follow each line's ready indication.
// - Codec-ready bits gate nothing; software checks them before starting engines.
// - Bit-clock-stopped reads 1 after four PCI clocks without an edge.
// - S/PDIF summary bit is high while any of its status bits is set.
// - PCM In 2 summary bit is high while any of its status bits is set.
// - Mic In 2 summary bit is high while any of its status bits is set.
// - Sample-capability field reads constant 01.
// - Multichannel capability field reads its fixed reset-default value.
// - Modem and audio semaphores are plain read/write bits without effect.
// - Semaphores live in suspend domain, cleared only by suspend reset.
// - Codec read timeout sets a flag held until software writes 1.
// - Slot 12 bits 3..1 read back at positions 14..12.
// - Slot 12 bit 0 sets GPI change flag; write 1 clears it.
// - Resume interrupt raised only when that line's enable is set.

module alg_status
  import alg_pkg::*;
(
  input  wire logic                 CLK,
  input  wire logic                 RSTN,
  input  wire logic                 SUSPEND_RSTN,
  input  wire logic                 FUNC_RESET,
  input  wire logic [15:0]          BUS_MASTER_IO_BASE,
  input  wire alg_io_req_t          IO_REQ,
  output var  logic [31:0]          IO_RDATA,
  output var  logic                 IO_ACK,
  input  wire logic                 BIT_CLK,
  input  wire logic [ALG_LINES-1:0] SERIAL_DATA_INPUT_LINE_READY,
  input  wire logic [ALG_LINES-1:0] SERIAL_DATA_INPUT_LINE_RESUME,
  input  wire alg_chan_stat_t       CHAN_STATUS,
  input  wire logic                 SLOT12_VALID,
  input  wire logic [3:0]           SLOT12_GPI,
  input  wire logic                 READ_TIMEOUT,
  input  wire logic [ALG_LINES-1:0] LINE_RESUME_IRQ_ENABLE,
  input  wire logic                 GPI_IRQ_ENABLE,
  output var  logic                 RESUME_IRQ,
  output var  logic                 GPI_IRQ
);

  // ********************************************************************
  // Helper functions
  // ********************************************************************

  // Sticky bit update: the set side wins so no event is lost on a clear
  function automatic logic sticky(input logic cur,
                                  input logic set,
                                  input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  // Expand byte enables into a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic [6:0]           sync1_ff;
  logic [6:0]           sync2_ff;
  logic                 bclk_d_ff;
  logic [ALG_LINES-1:0] resume_d_ff;
  logic [4:0]           idle_cnt_ff;
  logic [4:0]           nxt_idle_cnt;
  logic                 bclk_stop_ff;
  logic [ALG_LINES-1:0] ready_ff;
  logic [ALG_LINES-1:0] resume_flag_ff;
  logic [ALG_LINES-1:0] nxt_resume_flag;
  logic                 read_tmo_ff;
  logic                 gpi_chg_ff;
  logic [2:0]           gpi_bits_ff;
  logic                 modem_sem_ff;
  logic                 audio_sem_ff;
  logic                 spdif_irq_ff;
  logic                 pcm2_irq_ff;
  logic                 mic2_irq_ff;
  logic [31:0]          rdata_ff;
  logic                 ack_ff;
  logic                 resume_irq_ff;
  logic                 gpi_irq_ff;

  wire logic [15:0]          reg_addr;
  wire logic                 addr_hit;
  wire logic                 wr_hit;
  wire logic                 rd_hit;
  wire logic [31:0]          wr_ones;
  wire logic                 bclk_s;
  wire logic [ALG_LINES-1:0] ready_s;
  wire logic [ALG_LINES-1:0] resume_s;
  wire logic                 bclk_edge;
  wire logic [ALG_LINES-1:0] resume_evt;
  wire logic [ALG_LINES-1:0] resume_clr;
  wire logic                 read_tmo_clr;
  wire logic                 gpi_chg_set;
  wire logic                 gpi_chg_clr;
  wire logic [31:0]          status_word;

  // ********************************************************************
  // Register decode
  // ********************************************************************

  // Any byte lane inside the aligned word selects the register
  assign reg_addr = 16'(BUS_MASTER_IO_BASE + ALG_LGS_OFFSET);  // Wraps inside the I/O space
  assign addr_hit = (IO_REQ.addr[15:2] == reg_addr[15:2]);
  assign wr_hit   = IO_REQ.wr & addr_hit;
  assign rd_hit   = IO_REQ.rd & addr_hit;
  assign wr_ones  = wr_hit ? (IO_REQ.wdata & be_mask(IO_REQ.be)) : 32'h0000_0000;

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************

  // Bit clock, ready and resume come from the link side; two stages each
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      sync1_ff <= 7'h00;
      sync2_ff <= 7'h00;
    end else begin
      sync1_ff <= {SERIAL_DATA_INPUT_LINE_RESUME, SERIAL_DATA_INPUT_LINE_READY, BIT_CLK};
      sync2_ff <= sync1_ff;
    end
  end

  assign bclk_s   = sync2_ff[0];
  assign ready_s  = sync2_ff[3:1];
  assign resume_s = sync2_ff[6:4];

  // Delayed copies for edge detection, taken from the second stage only
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      bclk_d_ff   <= 1'b0;
      resume_d_ff <= 3'h0;
    end else begin
      bclk_d_ff   <= bclk_s;
      resume_d_ff <= resume_s;
    end
  end

  assign bclk_edge  = bclk_s ^ bclk_d_ff;
  assign resume_evt = resume_s & ~resume_d_ff;   // One pulse per resume request

  // ********************************************************************
  // Bit clock watchdog
  // ********************************************************************

  // Counter saturates so a long stop cannot wrap back to running
  assign nxt_idle_cnt = bclk_edge ? 5'h00 :
                        (idle_cnt_ff == ALG_BCLK_STOP_LIMIT) ? idle_cnt_ff :
                        5'(idle_cnt_ff + 5'h01);

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      idle_cnt_ff  <= 5'h00;
      bclk_stop_ff <= 1'b0;
    end else begin
      idle_cnt_ff  <= nxt_idle_cnt;
      bclk_stop_ff <= (nxt_idle_cnt == ALG_BCLK_STOP_LIMIT);
    end
  end

  // ********************************************************************
  // Codec ready and channel summaries
  // ********************************************************************

  // Ready bits are status only; the DMA engines never look at them
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ready_ff <= 3'h0;
    end else begin
      ready_ff <= ready_s;
    end
  end

  // Summaries follow the channel status bits, set and clear alike
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      spdif_irq_ff <= 1'b0;
      pcm2_irq_ff  <= 1'b0;
      mic2_irq_ff  <= 1'b0;
    end else begin
      spdif_irq_ff <= |CHAN_STATUS.spdif;
      pcm2_irq_ff  <= |CHAN_STATUS.pcm_in2;
      mic2_irq_ff  <= |CHAN_STATUS.mic_in2;
    end
  end

  // ********************************************************************
  // Sticky event flags
  // ********************************************************************

  assign resume_clr = {wr_ones[ALG_POS_L2_RESUME],
                       wr_ones[ALG_POS_L1_RESUME],
                       wr_ones[ALG_POS_L0_RESUME]};
  assign read_tmo_clr = wr_ones[ALG_POS_READ_TMO];
  assign gpi_chg_set  = SLOT12_VALID & SLOT12_GPI[0];
  assign gpi_chg_clr  = wr_ones[ALG_POS_GPI_CHG];

  // Resume flags per line; interrupt enables do not gate the record
  always_comb begin
    nxt_resume_flag = resume_flag_ff;
    for (int i = 0; i < ALG_LINES; i++) begin
      nxt_resume_flag[i] = sticky(resume_flag_ff[i], resume_evt[i], resume_clr[i]);
    end
  end

  // Function reset is deliberately absent here so flags survive D3 to D0
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      resume_flag_ff <= 3'h0;
      read_tmo_ff    <= 1'b0;
      gpi_chg_ff     <= 1'b0;
    end else begin
      resume_flag_ff <= nxt_resume_flag;
      read_tmo_ff    <= sticky(read_tmo_ff, READ_TIMEOUT, read_tmo_clr);
      gpi_chg_ff     <= sticky(gpi_chg_ff, gpi_chg_set, gpi_chg_clr);
    end
  end

  // ********************************************************************
  // Slot 12 GPI snapshot
  // ********************************************************************

  // Holds the last frame's bits; a function reset returns it to zero
  always_ff @(posedge CLK) begin
    if (!RSTN || FUNC_RESET) begin
      gpi_bits_ff <= 3'h0;
    end else if (SLOT12_VALID) begin
      gpi_bits_ff <= SLOT12_GPI[3:1];
    end
  end

  // ********************************************************************
  // Power-down semaphores
  // ********************************************************************

  // Suspend well: core and function resets cannot touch these bits
  always_ff @(posedge CLK) begin
    if (!SUSPEND_RSTN) begin
      modem_sem_ff <= ALG_LGS_RESET[ALG_POS_MODEM_SEM];
      audio_sem_ff <= ALG_LGS_RESET[ALG_POS_AUDIO_SEM];
    end else if (wr_hit) begin
      if (IO_REQ.be[2]) begin
        modem_sem_ff <= IO_REQ.wdata[ALG_POS_MODEM_SEM];
        audio_sem_ff <= IO_REQ.wdata[ALG_POS_AUDIO_SEM];
      end
    end
  end

  // ********************************************************************
  // Read path
  // ********************************************************************

  // Reserved positions are tied to zero; writes there land nowhere
  assign status_word = {2'b00,
                        resume_flag_ff[2],
                        ready_ff[2],
                        bclk_stop_ff,
                        spdif_irq_ff,
                        pcm2_irq_ff,
                        mic2_irq_ff,
                        ALG_SAMPLE_CAP,
                        ALG_MULTI_CAP,
                        2'b00,
                        modem_sem_ff,
                        audio_sem_ff,
                        read_tmo_ff,
                        gpi_bits_ff,
                        resume_flag_ff[1],
                        resume_flag_ff[0],
                        ready_ff[1],
                        ready_ff[0],
                        7'h00,
                        gpi_chg_ff};

  // Data is captured at the read strobe and answered one cycle later
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rdata_ff <= 32'h0000_0000;
      ack_ff   <= 1'b0;
    end else begin
      ack_ff <= wr_hit | rd_hit;
      if (rd_hit) begin
        rdata_ff <= status_word;
      end
    end
  end

  assign IO_RDATA = rdata_ff;
  assign IO_ACK   = ack_ff;

  // ********************************************************************
  // Interrupt requests
  // ********************************************************************

  // Level requests follow the sticky flags through their enables
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      resume_irq_ff <= 1'b0;
      gpi_irq_ff    <= 1'b0;
    end else begin
      resume_irq_ff <= |(nxt_resume_flag & LINE_RESUME_IRQ_ENABLE);
      gpi_irq_ff    <= sticky(gpi_chg_ff, gpi_chg_set, gpi_chg_clr) & GPI_IRQ_ENABLE;
    end
  end

  assign RESUME_IRQ = resume_irq_ff;
  assign GPI_IRQ    = gpi_irq_ff;

endmodule

`default_nettype wire

// >>> tb/alg_codec_model.sv
// Behavioural model of the codecs on the serial data input lines
`timescale 1ns/10ps
`default_nettype none
module alg_codec_model
  import alg_pkg::*;
(
  input  wire logic                 clk_run,
  input  wire logic                 cold_rstn,
  input  wire logic [ALG_LINES-1:0] ready_req,
  input  wire logic [ALG_LINES-1:0] wake_req,
  output var  logic                 bit_clk,
  output var  logic [ALG_LINES-1:0] line_ready,
  output var  logic [ALG_LINES-1:0] line_resume
);
  // 80 ns bit clock, odd start offset; stands low while the link is idle
  initial begin
    bit_clk = 1'b0;
    #13;
    forever begin
      #40;
      bit_clk = clk_run ? ~bit_clk : 1'b0;
    end
  end
  // Ready is sticky until a cold reset, so software may trust it once seen
  // One process owns the lines, so the time-zero value cannot race the update
  initial begin
    line_ready = '0;
    forever begin
      @(ready_req or cold_rstn);
      line_ready = cold_rstn ? (line_ready | ready_req) : '0;
    end
  end
  // A waking codec raises its data line
  assign line_resume = wake_req;
endmodule
`default_nettype wire

// >>> tb/alg_status_asserts.sv
// Port-level assertions for the global status register
`timescale 1ns/10ps
`default_nettype none
module alg_status_asserts
  import alg_pkg::*;
(
  input wire logic                 CLK,
  input wire logic                 RSTN,
  input wire logic                 FUNC_RESET,
  input wire logic [15:0]          BUS_MASTER_IO_BASE,
  input wire alg_io_req_t          IO_REQ,
  input wire logic [31:0]          IO_RDATA,
  input wire logic                 IO_ACK,
  input wire logic                 BIT_CLK,
  input wire alg_chan_stat_t       CHAN_STATUS,
  input wire logic                 SLOT12_VALID,
  input wire logic [3:0]           SLOT12_GPI,
  input wire logic                 READ_TIMEOUT,
  input wire logic [ALG_LINES-1:0] LINE_RESUME_IRQ_ENABLE,
  input wire logic                 GPI_IRQ_ENABLE,
  input wire logic                 RESUME_IRQ,
  input wire logic                 GPI_IRQ
);
  logic [15:0] reg_addr;
  logic        hit;
  logic        hit_rd;
  logic        bclk_ff;
  logic        tmo_ff;
  logic [2:0]  gpi_ff;
  logic [5:0]  idle_ff;
  // Register decode as seen from the bus
  assign reg_addr = BUS_MASTER_IO_BASE + ALG_LGS_OFFSET;
  assign hit      = (IO_REQ.rd | IO_REQ.wr) && IO_REQ.addr[15:2] == reg_addr[15:2];
  assign hit_rd   = hit && IO_REQ.rd;
  // Expected sticky state; idle count saturates so a long stop never wraps
  always_ff @(posedge CLK) begin
    bclk_ff <= BIT_CLK;
    if (!RSTN || bclk_ff != BIT_CLK) idle_ff <= 6'h00;
    else if (idle_ff != 6'h3f) idle_ff <= idle_ff + 6'h01;
    if (!RSTN || FUNC_RESET) gpi_ff <= 3'h0;
    else if (SLOT12_VALID) gpi_ff <= SLOT12_GPI[3:1];
    if (!RSTN || READ_TIMEOUT) tmo_ff <= RSTN;
    else if (hit && IO_REQ.wr && IO_REQ.be[1] && IO_REQ.wdata[15]) tmo_ff <= 1'b0;
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  AST_ACK: assert property (hit |=> IO_ACK)
    else $error("register access not acknowledged");
  AST_CAP: assert property (hit_rd |=> {IO_RDATA[31:30], IO_RDATA[23:18]} == 8'h1c)
    else $error("fixed or reserved fields wrong");
  AST_TMO: assert property (hit_rd |=> IO_RDATA[15] == $past(tmo_ff))
    else $error("read timeout flag wrong");
  AST_SUM: assert property (hit_rd && $stable(CHAN_STATUS) && $past(RSTN) |=>
    IO_RDATA[26:24] == {|$past(CHAN_STATUS.spdif), |$past(CHAN_STATUS.pcm_in2),
                        |$past(CHAN_STATUS.mic_in2)}) else $error("summary bits wrong");
  AST_GPIB: assert property (hit_rd |=> IO_RDATA[14:12] == $past(gpi_ff))
    else $error("slot 12 bits wrong");
  AST_GIRQ: assert property (SLOT12_VALID && SLOT12_GPI[0] && GPI_IRQ_ENABLE |=> GPI_IRQ)
    else $error("gpi interrupt missing");
  AST_RIRQ: assert property (RESUME_IRQ |-> $past(LINE_RESUME_IRQ_ENABLE) != 3'h0)
    else $error("resume interrupt without enable");
  AST_BSTOP: assert property (hit_rd && idle_ff > 6'd32 |=> IO_RDATA[27])
    else $error("stopped bit clock not flagged");
  AST_BRUN: assert property (hit_rd && idle_ff inside {[6'd6:6'd18]} |=> !IO_RDATA[27])
    else $error("running bit clock flagged stopped");
  COV_STOP: cover property (hit_rd && idle_ff > 6'd32);
  COV_RIRQ: cover property (RESUME_IRQ);
  COV_GIRQ: cover property (GPI_IRQ);
endmodule
bind alg_status alg_status_asserts alg_status_asserts_i (
  .CLK(CLK), .RSTN(RSTN), .FUNC_RESET(FUNC_RESET), .BUS_MASTER_IO_BASE(BUS_MASTER_IO_BASE),
  .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA), .IO_ACK(IO_ACK), .BIT_CLK(BIT_CLK),
  .CHAN_STATUS(CHAN_STATUS), .SLOT12_VALID(SLOT12_VALID), .SLOT12_GPI(SLOT12_GPI),
  .READ_TIMEOUT(READ_TIMEOUT), .LINE_RESUME_IRQ_ENABLE(LINE_RESUME_IRQ_ENABLE),
  .GPI_IRQ_ENABLE(GPI_IRQ_ENABLE), .RESUME_IRQ(RESUME_IRQ), .GPI_IRQ(GPI_IRQ)
);
`default_nettype wire

// >>> tb/tb_alg_status.sv
// Self-checking bench for the global status register
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_alg_status
  import alg_pkg::*;
  ;
  logic           clk, rstn, srstn, func_rst, vld, tmo, gpi_en, run, cold;
  logic           ack, res_irq, gpi_irq, bclk, sh_tmo, sh_chg, sh_bcs;
  logic [1:0]     sh_sem;
  logic [2:0]     rdy_req, wake, rdy, resm, res_en, sh_res, sh_gpi;
  logic [3:0]     gpi;
  logic [15:0]    base;
  logic [31:0]    rdata;
  alg_io_req_t    req;
  alg_chan_stat_t chan;
  int             err_count, compares, seed, k;
  alg_status alg_status_i (
    .CLK(clk), .RSTN(rstn), .SUSPEND_RSTN(srstn), .FUNC_RESET(func_rst),
    .BUS_MASTER_IO_BASE(base), .IO_REQ(req), .IO_RDATA(rdata), .IO_ACK(ack),
    .BIT_CLK(bclk), .SERIAL_DATA_INPUT_LINE_READY(rdy),
    .SERIAL_DATA_INPUT_LINE_RESUME(resm), .CHAN_STATUS(chan), .SLOT12_VALID(vld),
    .SLOT12_GPI(gpi), .READ_TIMEOUT(tmo), .LINE_RESUME_IRQ_ENABLE(res_en),
    .GPI_IRQ_ENABLE(gpi_en), .RESUME_IRQ(res_irq), .GPI_IRQ(gpi_irq)
  );
  alg_codec_model alg_codec_model_i (
    .clk_run(run), .cold_rstn(cold), .ready_req(rdy_req), .wake_req(wake),
    .bit_clk(bclk), .line_ready(rdy), .line_resume(resm)
  );
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Expected register word from the shadow state and the codec lines
  function automatic logic [31:0] exp_word();
    return {2'h0, sh_res[2], rdy[2], sh_bcs, |chan.spdif, |chan.pcm_in2, |chan.mic_in2,
            2'h1, 2'h3, 2'h0, sh_sem, sh_tmo, sh_gpi, sh_res[1:0], rdy[1:0], 7'h00, sh_chg};
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One-cycle request; the idle cycle before it keeps strobes from merging
  task automatic rw(input logic w, input logic [15:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(negedge clk);
    req = '{wr: w, rd: !w, addr: a, be: s, wdata: d};
    @(negedge clk);
    req = '0;
  endtask
  task automatic rd(input logic [31:0] e);
    rw(1'b0, base + ALG_LGS_OFFSET, 4'hf, 32'h0);
    `CHK("read ack", 1'b1, ack)
    `CHK("status word", e, rdata)
  endtask
  // Write, then apply write-one-to-clear and storage effects to the shadow
  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    rw(1'b1, base + ALG_LGS_OFFSET, s, d);
    `CHK("write ack", 1'b1, ack)
    if (s[2]) sh_sem = d[17:16];
    if (s[3] && d[29]) sh_res[2] = 1'b0;
    if (s[1]) sh_tmo &= ~d[15];
    if (s[1]) sh_res[1:0] &= ~d[11:10];
    if (s[0] && d[0]) sh_chg = 1'b0;
  endtask
  task automatic fpulse();
    @(negedge clk) func_rst = 1'b1;
    @(negedge clk) func_rst = 1'b0;
    sh_gpi = 3'h0;
  endtask
  // Hang guard, far beyond the length of the run
  initial begin
    #400000;
    err_count++;
    end_of_test();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 65;
    {rstn, srstn, func_rst, vld, tmo, gpi_en, cold, rdy_req, wake, res_en, gpi} = '0;
    {sh_tmo, sh_chg, sh_bcs, sh_sem, sh_res, sh_gpi} = '0;
    run  = 1'b1;
    chan = '0;
    req  = '0;
    base = 16'($random(seed));
    repeat (8) @(negedge clk);
    {rstn, srstn, cold} = 3'h7;
    rd(exp_word());
    rw(1'b1, base + 16'h0034, 4'hf, 32'hffff_ffff);
    `CHK("stray ack", 1'b0, ack)
    rd(exp_word());
    wr(4'hf, 32'hffff_ffff);
    rd(exp_word());
    @(negedge clk) tmo = 1'b1;
    @(negedge clk) tmo = 1'b0;
    sh_tmo = 1'b1;
    fpulse();
    rd(exp_word());
    wr(4'hd, 32'h0000_8000);
    rd(exp_word());
    wr(4'h2, 32'h0000_8000);
    rd(exp_word());
    for (k = 0; k < 8; k++) begin
      @(negedge clk);
      gpi = (k == 0) ? 4'hf : 4'($random(seed));
      {vld, gpi_en} = {1'b1, k[0]};
      @(negedge clk) vld = 1'b0;
      {sh_gpi, sh_chg} = {gpi[3:1], sh_chg | gpi[0]};
      `CHK("gpi irq", sh_chg & gpi_en, gpi_irq)
      rd(exp_word());
      if (k == 3) wr(4'h1, 32'h0000_0001);
    end
    fpulse();
    rd(exp_word());
    for (k = 0; k < 3; k++) begin
      rdy_req = 3'($random(seed));
      repeat (4) @(negedge clk);
      rdy_req = 3'h0;
      rd(exp_word());
    end
    for (k = 0; k < 3; k++) begin
      res_en = (k == 1) ? 3'h0 : 3'(1 << k);
      wake = 3'(1 << k);
      repeat (4) @(negedge clk);
      wake = 3'h0;
      sh_res[k] = 1'b1;
      `CHK("resume irq", res_en[k], res_irq)
      fpulse();
      rd(exp_word());
      wr(4'ha, (k == 2) ? 32'h2000_0000 : 32'(32'h400 << k));
      rd(exp_word());
      `CHK("resume irq clear", 1'b0, res_irq)
    end
    for (k = 0; k < 10; k++) begin
      chan = alg_chan_stat_t'((k == 0) ? 9'h1ff : (k == 9) ? 9'h0 : 9'($random(seed)));
      repeat (2) @(negedge clk);
      rd(exp_word());
    end
    run = 1'b0;
    repeat (60) @(negedge clk);
    sh_bcs = 1'b1;
    rd(exp_word());
    run = 1'b1;
    repeat (40) @(negedge clk);
    sh_bcs = 1'b0;
    rd(exp_word());
    wr(4'h4, 32'h0002_0000);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    {sh_res, sh_tmo, sh_gpi, sh_chg} = '0;
    repeat (4) @(negedge clk);
    rd(exp_word());
    {rstn, srstn} = 2'h0;
    repeat (2) @(negedge clk);
    {rstn, srstn} = 2'h3;
    sh_sem = 2'h0;
    repeat (4) @(negedge clk);
    rd(exp_word());
    end_of_test();
  end
endmodule
`undef CHK
`default_nettype wire
